// >>> cbbl_core.sv
// Notes on behaviour
// - overflow-clear branch: if V is 0, pc gets pc+k+1; 1 or 2 cycles.
// - irq-enabled branch jumps to pc+k+1 only when I is 1; 1 or 2 cycles.
// - irq-disabled branch jumps to pc+k+1 only when I is 0; 1 or 2 cycles.
// - io bit set writes selected io bit to one, flags kept, two cycles.
// - io bit clear writes selected io bit to zero, flags kept, two cycles.
// - rotate left through carry: bit0 from C, C from old bit7, ZCNV, one cycle.
// - rotate right through carry: bit7 from C, C from old bit0, ZCNV, one cycle.
// - bit store copies a register bit into T; only T changes; one cycle.
// - bit load writes T into a register bit; no flag changes; one cycle.
// - half carry set and clear ops touch only H, one cycle.
// - overflow set and clear ops touch only V, one cycle.
// - sign set and clear ops touch only S, one cycle.
// - post-increment load reads memory at pointer, then pointer plus one; two cycles.
// - pre-decrement load lowers pointer first, then reads there; two cycles.
//
// Added by the designer: the Wishbone register port and the address map.
module cbbl_core (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic      [15:0] o_mem_addr,
    output logic             o_mem_rd,
    input  wire logic [7:0]  i_mem_rdata,
    output logic      [5:0]  o_io_addr,
    output logic             o_io_rd,
    input  wire logic [7:0]  i_io_rdata,
    output logic             o_io_wr,
    output logic      [7:0]  o_io_wdata,
    output logic             o_busy,
    output logic             o_done
);
    cbbl_alu_if alu_bus ();

    cbbl_pkg::cbbl_state_t state_q;
    cbbl_pkg::cbbl_state_t state_d;
    logic [24:0] insn_q;
    logic [7:0]  flags_q;
    logic [15:0] pc_q;
    logic [15:0] ptr_q;
    logic        taken_q;
    logic [7:0]  gpr_q [cbbl_pkg::GPR_N];
    logic [31:0] rdata_q;
    logic        ack_q;
    logic [15:0] mem_addr_q;
    logic        mem_rd_q;
    logic [5:0]  io_addr_q;
    logic        io_rd_q;
    logic        io_wr_q;
    logic [7:0]  io_wdata_q;
    logic        busy_q;
    logic        done_q;

    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return (old & ~m) | (nw & m);
    endfunction

    // bus decode
    wire        req       = i_wb_cyc & i_wb_stb;
    wire        wr_fire   = req & i_wb_we & ack_q;
    wire [5:0]  word      = i_wb_adr[7:2];
    wire        hit_insn  = word == cbbl_pkg::OFF_INSN[7:2];
    wire        hit_flags = word == cbbl_pkg::OFF_FLAGS[7:2];
    wire        hit_pc    = word == cbbl_pkg::OFF_PC[7:2];
    wire        hit_ptr   = word == cbbl_pkg::OFF_PTR[7:2];
    wire        hit_stat  = word == cbbl_pkg::OFF_STAT[7:2];
    wire        hit_gpr   = i_wb_adr[7:5] == cbbl_pkg::GPR_HI;
    wire [2:0]  gpr_idx   = i_wb_adr[4:2];
    wire        idle      = state_q == cbbl_pkg::ST_IDLE;
    // software writes to state are refused while an instruction runs
    wire        sw_wr     = wr_fire & idle;
    wire        start     = sw_wr & hit_insn;
    wire [4:0]  start_op  = i_wb_dat[cbbl_pkg::OP_LSB +: cbbl_pkg::OP_W];
    wire        start_io  = (start_op == cbbl_pkg::OP_IO_SET) |
                            (start_op == cbbl_pkg::OP_IO_CLR);

    // instruction fields
    wire [4:0]  op      = insn_q[cbbl_pkg::OP_LSB +: cbbl_pkg::OP_W];
    wire [2:0]  rd_idx  = insn_q[cbbl_pkg::RD_LSB +: cbbl_pkg::GPR_IW];
    wire [2:0]  bit_sel = insn_q[cbbl_pkg::BIT_LSB +: cbbl_pkg::BIT_W];
    wire [7:0]  k       = insn_q[cbbl_pkg::K_LSB +: cbbl_pkg::K_W];
    wire [5:0]  io_a    = insn_q[cbbl_pkg::IOA_LSB +: cbbl_pkg::IOAW];
    wire        is_br   = (op == cbbl_pkg::OP_BR_VC) | (op == cbbl_pkg::OP_BR_IE) |
                          (op == cbbl_pkg::OP_BR_ID);
    wire        is_io   = (op == cbbl_pkg::OP_IO_SET) | (op == cbbl_pkg::OP_IO_CLR);
    wire        is_pre  = op == cbbl_pkg::OP_LD_DEC;
    wire        is_ld   = (op == cbbl_pkg::OP_LD_INC) | is_pre;
    wire        is_wgpr = (op == cbbl_pkg::OP_ROL) | (op == cbbl_pkg::OP_ROR) |
                          (op == cbbl_pkg::OP_BLD);

    // sequencing
    wire        in_exec  = state_q == cbbl_pkg::ST_EXEC;
    wire        in_fin   = state_q == cbbl_pkg::ST_FIN;
    wire        need_fin = (is_br & alu_bus.take) | is_io | is_ld;
    wire        finish   = (in_exec & ~need_fin) | in_fin;
    always_comb begin
        state_d = state_q;
        case (state_q)
            cbbl_pkg::ST_IDLE: if (start) state_d = cbbl_pkg::ST_EXEC;
            cbbl_pkg::ST_EXEC: state_d = need_fin ? cbbl_pkg::ST_FIN : cbbl_pkg::ST_IDLE;
            cbbl_pkg::ST_FIN:  state_d = cbbl_pkg::ST_IDLE;
            default:           state_d = cbbl_pkg::ST_IDLE;
        endcase
    end

    // operand path and writeback
    wire [7:0]  opnd     = is_io ? i_io_rdata : gpr_q[rd_idx];
    wire        gpr_we   = (in_exec & is_wgpr) | (in_fin & is_ld);
    wire [7:0]  gpr_wd   = is_ld ? i_mem_rdata : alu_bus.result;
    wire [15:0] k_ext    = {{8{k[7]}}, k};
    wire [15:0] br_tgt   = pc_q + k_ext + cbbl_pkg::STEP;
    wire [15:0] pc_next  = (in_fin & is_br) ? br_tgt : pc_q + cbbl_pkg::STEP;
    wire [15:0] ptr_dec  = ptr_q - cbbl_pkg::STEP;
    wire [31:0] pc_sw    = lane_merge(32'(pc_q), i_wb_dat, i_wb_sel);
    wire [31:0] ptr_sw   = lane_merge(32'(ptr_q), i_wb_dat, i_wb_sel);
    wire [31:0] fl_sw    = lane_merge(32'(flags_q), i_wb_dat, i_wb_sel);

    wire [7:0]  flags_d  = (sw_wr & hit_flags) ? fl_sw[7:0] :
                           in_exec ? alu_bus.flags_out : flags_q;
    wire [15:0] pc_d     = (sw_wr & hit_pc) ? pc_sw[15:0] :
                           finish ? pc_next : pc_q;
    wire [15:0] ptr_d    = (sw_wr & hit_ptr) ? ptr_sw[15:0] :
                           (in_exec & is_pre) ? ptr_dec :
                           (in_fin & is_ld & ~is_pre) ? ptr_q + cbbl_pkg::STEP :
                           ptr_q;
    wire [31:0] stat     = {30'h0, taken_q, ~idle};
    wire [31:0] rd_mux   = hit_insn  ? 32'(insn_q) :
                           hit_flags ? 32'(flags_q) :
                           hit_pc    ? 32'(pc_q) :
                           hit_ptr   ? 32'(ptr_q) :
                           hit_stat  ? stat :
                           hit_gpr   ? 32'(gpr_q[gpr_idx]) : 32'h0;

    assign alu_bus.op       = op;
    assign alu_bus.opnd     = opnd;
    assign alu_bus.bit_sel  = bit_sel;
    assign alu_bus.flags_in = flags_q;

    cbbl_alu u_alu (
        .a (alu_bus)
    );

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= req & ~ack_q;
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= cbbl_pkg::ST_IDLE;
            insn_q  <= cbbl_pkg::RST_INSN;
            flags_q <= cbbl_pkg::RST_FLAGS;
            pc_q    <= cbbl_pkg::RST_PC;
            ptr_q   <= cbbl_pkg::RST_PTR;
            taken_q <= 1'b0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            insn_q  <= start ? i_wb_dat[cbbl_pkg::INSN_W-1:0] : insn_q;
            flags_q <= flags_d;
            pc_q    <= pc_d;
            ptr_q   <= ptr_d;
            taken_q <= in_exec ? (is_br & alu_bus.take) : taken_q;
            busy_q  <= state_d != cbbl_pkg::ST_IDLE;
            done_q  <= finish;
        end
    end

    // io read-modify-write: read strobe in cycle 1, write strobe in cycle 2
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            io_rd_q    <= 1'b0;
            io_addr_q  <= 6'h00;
            io_wr_q    <= 1'b0;
            io_wdata_q <= 8'h00;
        end else begin
            io_rd_q    <= start & start_io;
            io_addr_q  <= (start & start_io) ?
                          i_wb_dat[cbbl_pkg::IOA_LSB +: cbbl_pkg::IOAW] : io_addr_q;
            io_wr_q    <= in_exec & is_io;
            io_wdata_q <= (in_exec & is_io) ? alu_bus.result : io_wdata_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mem_rd_q   <= 1'b0;
            mem_addr_q <= 16'h0000;
        end else begin
            mem_rd_q   <= in_exec & is_ld;
            mem_addr_q <= (in_exec & is_ld) ? (is_pre ? ptr_dec : ptr_q) : mem_addr_q;
        end
    end

    for (genvar g = 0; g < cbbl_pkg::GPR_N; g++) begin : g_gpr
        wire sw = sw_wr & hit_gpr & (gpr_idx == 3'(g)) & i_wb_sel[0];
        wire hw = gpr_we & (rd_idx == 3'(g));
        always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
                gpr_q[g] <= cbbl_pkg::RST_GPR;
            end else if (sw) begin
                gpr_q[g] <= i_wb_dat[7:0];
            end else if (hw) begin
                gpr_q[g] <= gpr_wd;
            end
        end
    end

    assign o_wb_dat   = rdata_q;
    assign o_wb_ack   = ack_q;
    assign o_mem_addr = mem_addr_q;
    assign o_mem_rd   = mem_rd_q;
    assign o_io_addr  = io_addr_q;
    assign o_io_rd    = io_rd_q;
    assign o_io_wr    = io_wr_q;
    assign o_io_wdata = io_wdata_q;
    assign o_busy     = busy_q;
    assign o_done     = done_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_vc_branch_taken: assert property (
        (in_exec && op == cbbl_pkg::OP_BR_VC && !flags_q[cbbl_pkg::FLG_V])
        |=> in_fin ##1 (idle && pc_q == $past(br_tgt) && done_q))
        else $error("overflow clear branch target or timing wrong");

    a_ie_branch_skip: assert property (
        (in_exec && op == cbbl_pkg::OP_BR_IE && !flags_q[cbbl_pkg::FLG_I])
        |=> (idle && done_q && pc_q == $past(pc_q) + cbbl_pkg::STEP))
        else $error("irq enabled branch not skipped in one cycle");

    a_id_branch_path: assert property (
        (in_exec && op == cbbl_pkg::OP_BR_ID)
        |=> (flags_q[cbbl_pkg::FLG_I] == $past(flags_q[cbbl_pkg::FLG_I]))
            && (in_fin == !$past(flags_q[cbbl_pkg::FLG_I])))
        else $error("irq disabled branch decision wrong");

    a_io_set_write: assert property (
        (in_exec && op == cbbl_pkg::OP_IO_SET)
        |=> (io_wr_q && io_wdata_q == ($past(i_io_rdata) | 8'(8'h01 << $past(bit_sel)))
             && flags_q == $past(flags_q)) ##1 (done_q && !io_wr_q))
        else $error("io bit set write wrong");

    a_io_clr_write: assert property (
        (in_exec && op == cbbl_pkg::OP_IO_CLR)
        |=> (io_wr_q && io_wdata_q == ($past(i_io_rdata) & ~8'(8'h01 << $past(bit_sel)))
             && flags_q == $past(flags_q)) ##1 done_q)
        else $error("io bit clear write wrong");

    a_rol_result: assert property (
        (in_exec && op == cbbl_pkg::OP_ROL)
        |=> (gpr_q[$past(rd_idx)] == {$past(opnd[6:0]), $past(flags_q[cbbl_pkg::FLG_C])})
            && flags_q[cbbl_pkg::FLG_C] == $past(opnd[7]) && done_q)
        else $error("rotate left result or carry wrong");

    a_ror_result: assert property (
        (in_exec && op == cbbl_pkg::OP_ROR)
        |=> (gpr_q[$past(rd_idx)] == {$past(flags_q[cbbl_pkg::FLG_C]), $past(opnd[7:1])})
            && flags_q[cbbl_pkg::FLG_C] == $past(opnd[0]) && done_q)
        else $error("rotate right result or carry wrong");

    a_rot_zero_neg: assert property (
        (in_exec && (op == cbbl_pkg::OP_ROL || op == cbbl_pkg::OP_ROR))
        |=> flags_q[cbbl_pkg::FLG_Z] == (gpr_q[$past(rd_idx)] == 8'h00)
            && flags_q[cbbl_pkg::FLG_N] == gpr_q[$past(rd_idx)][7])
        else $error("rotate zero or negative flag wrong");

    a_bit_store_t: assert property (
        (in_exec && op == cbbl_pkg::OP_BST)
        |=> flags_q[cbbl_pkg::FLG_T] == $past(opnd[bit_sel])
            && (flags_q & 8'hbf) == ($past(flags_q) & 8'hbf))
        else $error("bit store to transfer flag wrong");

    a_bit_load_reg: assert property (
        (in_exec && op == cbbl_pkg::OP_BLD)
        |=> gpr_q[$past(rd_idx)][$past(bit_sel)] == $past(flags_q[cbbl_pkg::FLG_T])
            && flags_q == $past(flags_q))
        else $error("bit load from transfer flag wrong");

    a_half_carry_op: assert property (
        (in_exec && op == cbbl_pkg::OP_SEH) |=> flags_q == ($past(flags_q) | 8'h20))
        else $error("half carry set touched other flags");

    a_overflow_op: assert property (
        (in_exec && op == cbbl_pkg::OP_CLV) |=> flags_q == ($past(flags_q) & 8'hf7))
        else $error("overflow clear touched other flags");

    a_sign_op: assert property (
        (in_exec && op == cbbl_pkg::OP_SES) |=> flags_q == ($past(flags_q) | 8'h10))
        else $error("sign set touched other flags");

    a_load_post_inc: assert property (
        (in_exec && op == cbbl_pkg::OP_LD_INC)
        |=> (mem_rd_q && mem_addr_q == $past(ptr_q)) ##1
            (done_q && ptr_q == $past(mem_addr_q) + cbbl_pkg::STEP))
        else $error("post increment load wrong");

    a_load_pre_dec: assert property (
        (in_exec && op == cbbl_pkg::OP_LD_DEC)
        |=> (mem_rd_q && mem_addr_q == $past(ptr_q) - cbbl_pkg::STEP && ptr_q == mem_addr_q)
            ##1 (done_q && ptr_q == $past(ptr_q)))
        else $error("pre decrement load wrong");
endmodule

// >>> cbbl_pkg.sv
package cbbl_pkg;
    localparam int DW      = 8;
    localparam int AW      = 16;
    localparam int GPR_N   = 8;
    localparam int GPR_IW  = 3;
    localparam int IOAW    = 6;
    localparam int WB_AW   = 8;
    // instruction word fields
    localparam int OP_LSB  = 0;
    localparam int OP_W    = 5;
    localparam int RD_LSB  = 5;
    localparam int BIT_LSB = 8;
    localparam int BIT_W   = 3;
    localparam int K_LSB   = 11;
    localparam int K_W     = 8;
    localparam int IOA_LSB = 19;
    localparam int INSN_W  = 25;
    // register byte offsets
    localparam logic [7:0] OFF_INSN  = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_PC    = 8'h08;
    localparam logic [7:0] OFF_PTR   = 8'h0c;
    localparam logic [7:0] OFF_STAT  = 8'h10;
    localparam logic [2:0] GPR_HI    = 3'h1;
    // status register flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_TAKEN = 1;
    // opcodes
    localparam logic [4:0] OP_BR_VC  = 5'h00;
    localparam logic [4:0] OP_BR_IE  = 5'h01;
    localparam logic [4:0] OP_BR_ID  = 5'h02;
    localparam logic [4:0] OP_IO_SET = 5'h03;
    localparam logic [4:0] OP_IO_CLR = 5'h04;
    localparam logic [4:0] OP_ROL    = 5'h05;
    localparam logic [4:0] OP_ROR    = 5'h06;
    localparam logic [4:0] OP_BST    = 5'h07;
    localparam logic [4:0] OP_BLD    = 5'h08;
    localparam logic [4:0] OP_SEH    = 5'h09;
    localparam logic [4:0] OP_CLH    = 5'h0a;
    localparam logic [4:0] OP_SEV    = 5'h0b;
    localparam logic [4:0] OP_CLV    = 5'h0c;
    localparam logic [4:0] OP_SES    = 5'h0d;
    localparam logic [4:0] OP_CLS    = 5'h0e;
    localparam logic [4:0] OP_LD_INC = 5'h0f;
    localparam logic [4:0] OP_LD_DEC = 5'h10;
    // reset values and steps
    localparam logic [7:0]  RST_FLAGS = 8'h00;
    localparam logic [7:0]  RST_GPR   = 8'h00;
    localparam logic [15:0] RST_PC    = 16'h0000;
    localparam logic [15:0] RST_PTR   = 16'h0000;
    localparam logic [24:0] RST_INSN  = 25'h0000000;
    localparam logic [15:0] STEP      = 16'h0001;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_FIN  = 2'b11
    } cbbl_state_t;
endpackage

// >>> cbbl_alu_if.sv
interface cbbl_alu_if;
    logic [4:0] op;
    logic [7:0] opnd;
    logic [2:0] bit_sel;
    logic [7:0] flags_in;
    logic [7:0] result;
    logic [7:0] flags_out;
    logic       take;
    modport core (output op, opnd, bit_sel, flags_in, input result, flags_out, take);
    modport alu  (input op, opnd, bit_sel, flags_in, output result, flags_out, take);
endinterface

// >>> cbbl_alu.sv
module cbbl_alu (
    cbbl_alu_if.alu a
);
    logic [7:0] res;
    logic [7:0] flg;
    logic       tk;
    logic       rot;

    assign rot = (a.op == cbbl_pkg::OP_ROL) || (a.op == cbbl_pkg::OP_ROR);

    always_comb begin
        res = a.opnd;
        flg = a.flags_in;
        tk  = 1'b0;
        case (a.op)
            cbbl_pkg::OP_BR_VC:  tk = ~a.flags_in[cbbl_pkg::FLG_V];
            cbbl_pkg::OP_BR_IE:  tk = a.flags_in[cbbl_pkg::FLG_I];
            cbbl_pkg::OP_BR_ID:  tk = ~a.flags_in[cbbl_pkg::FLG_I];
            cbbl_pkg::OP_IO_SET: res[a.bit_sel] = 1'b1;
            cbbl_pkg::OP_IO_CLR: res[a.bit_sel] = 1'b0;
            cbbl_pkg::OP_ROL: begin
                res = {a.opnd[6:0], a.flags_in[cbbl_pkg::FLG_C]};
                flg[cbbl_pkg::FLG_C] = a.opnd[7];
            end
            cbbl_pkg::OP_ROR: begin
                res = {a.flags_in[cbbl_pkg::FLG_C], a.opnd[7:1]};
                flg[cbbl_pkg::FLG_C] = a.opnd[0];
            end
            cbbl_pkg::OP_BST: flg[cbbl_pkg::FLG_T] = a.opnd[a.bit_sel];
            cbbl_pkg::OP_BLD: res[a.bit_sel] = a.flags_in[cbbl_pkg::FLG_T];
            cbbl_pkg::OP_SEH: flg[cbbl_pkg::FLG_H] = 1'b1;
            cbbl_pkg::OP_CLH: flg[cbbl_pkg::FLG_H] = 1'b0;
            cbbl_pkg::OP_SEV: flg[cbbl_pkg::FLG_V] = 1'b1;
            cbbl_pkg::OP_CLV: flg[cbbl_pkg::FLG_V] = 1'b0;
            cbbl_pkg::OP_SES: flg[cbbl_pkg::FLG_S] = 1'b1;
            cbbl_pkg::OP_CLS: flg[cbbl_pkg::FLG_S] = 1'b0;
            default: ;
        endcase
        if (rot) begin
            flg[cbbl_pkg::FLG_Z] = (res == 8'h00);
            flg[cbbl_pkg::FLG_N] = res[7];
            // overflow follows the usual shift convention n xor c
            flg[cbbl_pkg::FLG_V] = res[7] ^ flg[cbbl_pkg::FLG_C];
        end
    end

    assign a.result    = res;
    assign a.flags_out = flg;
    assign a.take      = tk;
endmodule

// >>> cbbl_mem_model.sv
module cbbl_mem_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_mem_addr,
    input  wire logic        i_mem_rd,
    output logic      [7:0]  o_mem_rdata,
    input  wire logic [5:0]  i_io_addr,
    input  wire logic        i_io_rd,
    input  wire logic        i_io_wr,
    input  wire logic [7:0]  i_io_wdata,
    output logic      [7:0]  o_io_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] io_q [64];
    logic [7:0] mem_last_q = 8'h00;
    logic [7:0] io_last_q  = 8'h00;
    // idle lines toggle so a late sample cannot match by luck
    assign o_mem_rdata = i_mem_rd ? (i_mem_addr[7:0] ^ i_mem_addr[15:8] ^ 8'h3c)
                                  : ~mem_last_q;
    assign o_io_rdata  = i_io_rd ? io_q[i_io_addr] : ~io_last_q;
    initial for (int a = 0; a < 64; a++) io_q[a] = 8'(a) ^ 8'h55;
    always @(posedge i_clk) begin
        mem_last_q <= o_mem_rdata;
        io_last_q  <= o_io_rdata;
        if (i_io_wr)
            io_q[i_io_addr] <= i_io_wdata;
    end
endmodule

// >>> cbbl_core_tb.sv
module cbbl_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat;
    logic        ack, mrd, iord, iowr, busy, done;
    logic [15:0] maddr;
    logic [7:0]  mdat, iodat, iowd;
    logic [5:0]  ioa;
    int          n_errors = 0;
    int          checks = 0;

    cbbl_core cbbl_core_i (
        .i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack),
        .o_mem_addr(maddr), .o_mem_rd(mrd), .i_mem_rdata(mdat), .o_io_addr(ioa),
        .o_io_rd(iord), .i_io_rdata(iodat), .o_io_wr(iowr), .o_io_wdata(iowd),
        .o_busy(busy), .o_done(done));
    cbbl_mem_model cbbl_mem_model_i (
        .i_clk(clk), .i_mem_addr(maddr), .i_mem_rd(mrd), .o_mem_rdata(mdat),
        .i_io_addr(ioa), .i_io_rd(iord), .i_io_wr(iowr), .i_io_wdata(iowd),
        .o_io_rdata(iodat));

    always #25 clk = ~clk;

    task automatic summarize();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; ack is taken at the edge, before the slave updates
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat;
        req <= 1'b0;
        if (n >= 20)
            chk("bus ack", 32'h0, 32'h1);
        if (n >= 20)
            summarize();
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rdat, exp);
    endtask

    function automatic logic [24:0] ins(logic [4:0] op, logic [2:0] r, logic [2:0] b,
                                        logic [7:0] k, logic [5:0] io);
        return {io, k, b, r, op};
    endfunction

    // pc is preset so every expected pc is absolute
    task automatic exec(input logic [24:0] insn, input int ncyc, input logic [15:0] pcx);
        int n;
        n = 0;
        bus(1'b1, cbbl_pkg::OFF_PC, 32'h0100);
        bus(1'b1, cbbl_pkg::OFF_INSN, {7'h0, insn});
        do begin
            @(posedge clk);
            n++;
            if (n == 1)
                chk("busy", {31'h0, busy}, 32'h1);
        end while (done !== 1'b1 && n < 20);
        chk("cycles", n - 1, ncyc);
        if (n >= 20)
            summarize();
        rd("pc", cbbl_pkg::OFF_PC, {16'h0, pcx});
    endtask

    // offset -16 lands below the preset pc, so sign extension is exercised
    task automatic t_branch();
        logic [7:0] f;
        logic       tk;
        for (int op = 0; op < 3; op++) begin
            for (int j = 0; j < 2; j++) begin
                f = j ? 8'h88 : 8'h00;
                tk = (op == 1) ? j[0] : !j[0];
                bus(1'b1, cbbl_pkg::OFF_FLAGS, {24'h0, f});
                exec(ins(5'(op), 3'h0, 3'h0, 8'hf0, 6'h00), tk ? 2 : 1,
                     tk ? 16'h00f1 : 16'h0101);
                rd("taken", cbbl_pkg::OFF_STAT, {30'h0, tk, 1'b0});
                rd("branch flags", cbbl_pkg::OFF_FLAGS, {24'h0, f});
            end
        end
    endtask

    task automatic t_io();
        bus(1'b1, cbbl_pkg::OFF_FLAGS, 32'h2a);
        exec(ins(cbbl_pkg::OP_IO_SET, 3'h0, 3'h3, 8'h00, 6'h05), 2, 16'h0101);
        chk("io set", {24'h0, cbbl_mem_model_i.io_q[5]}, 32'h58);
        exec(ins(cbbl_pkg::OP_IO_CLR, 3'h0, 3'h4, 8'h00, 6'h05), 2, 16'h0101);
        chk("io clr", {24'h0, cbbl_mem_model_i.io_q[5]}, 32'h48);
        rd("io flags", cbbl_pkg::OFF_FLAGS, 32'h2a);
    endtask

    task automatic t_rot();
        bus(1'b1, 8'h28, 32'h81);
        bus(1'b1, cbbl_pkg::OFF_FLAGS, 32'h01);
        exec(ins(cbbl_pkg::OP_ROL, 3'h2, 3'h0, 8'h00, 6'h00), 1, 16'h0101);
        rd("rol", 8'h28, 32'h03);
        rd("rol flags", cbbl_pkg::OFF_FLAGS, 32'h09);
        exec(ins(cbbl_pkg::OP_ROR, 3'h2, 3'h0, 8'h00, 6'h00), 1, 16'h0101);
        rd("ror", 8'h28, 32'h81);
        rd("ror flags", cbbl_pkg::OFF_FLAGS, 32'h05);
        bus(1'b1, 8'h28, 32'h80);
        bus(1'b1, cbbl_pkg::OFF_FLAGS, 32'h00);
        exec(ins(cbbl_pkg::OP_ROL, 3'h2, 3'h0, 8'h00, 6'h00), 1, 16'h0101);
        rd("rol zero", 8'h28, 32'h00);
        rd("zero flags", cbbl_pkg::OFF_FLAGS, 32'h0b);
    endtask

    task automatic t_bits();
        logic [4:0] ops [6];
        logic [7:0] fx [6];
        ops = '{cbbl_pkg::OP_SEH, cbbl_pkg::OP_SEV, cbbl_pkg::OP_SES,
                cbbl_pkg::OP_CLH, cbbl_pkg::OP_CLV, cbbl_pkg::OP_CLS};
        fx  = '{8'h60, 8'h68, 8'h78, 8'h58, 8'h50, 8'h40};
        bus(1'b1, 8'h2c, 32'h10);
        bus(1'b1, 8'h30, 32'h00);
        bus(1'b1, cbbl_pkg::OFF_FLAGS, 32'h00);
        exec(ins(cbbl_pkg::OP_BST, 3'h3, 3'h4, 8'h00, 6'h00), 1, 16'h0101);
        rd("bst flags", cbbl_pkg::OFF_FLAGS, 32'h40);
        exec(ins(cbbl_pkg::OP_BLD, 3'h4, 3'h6, 8'h00, 6'h00), 1, 16'h0101);
        rd("bld", 8'h30, 32'h40);
        rd("bld flags", cbbl_pkg::OFF_FLAGS, 32'h40);
        for (int i = 0; i < 6; i++) begin
            exec(ins(ops[i], 3'h0, 3'h0, 8'h00, 6'h00), 1, 16'h0101);
            rd("flag op", cbbl_pkg::OFF_FLAGS, {24'h0, fx[i]});
        end
    endtask

    // model data is addr low ^ addr high ^ 3c, so 1234 reads 1a
    task automatic t_load();
        bus(1'b1, cbbl_pkg::OFF_PTR, 32'h1234);
        exec(ins(cbbl_pkg::OP_LD_INC, 3'h1, 3'h0, 8'h00, 6'h00), 2, 16'h0101);
        rd("ld inc", 8'h24, 32'h1a);
        rd("ptr inc", cbbl_pkg::OFF_PTR, 32'h1235);
        exec(ins(cbbl_pkg::OP_LD_DEC, 3'h5, 3'h0, 8'h00, 6'h00), 2, 16'h0101);
        rd("ld dec", 8'h34, 32'h1a);
        rd("ptr dec", cbbl_pkg::OFF_PTR, 32'h1234);
        rd("ld flags", cbbl_pkg::OFF_FLAGS, 32'h40);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_branch();
        t_io();
        t_rot();
        t_bits();
        t_load();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd("pc after reset", cbbl_pkg::OFF_PC, 32'h0);
        rd("ptr after reset", cbbl_pkg::OFF_PTR, 32'h0);
        summarize();
    end
endmodule
